// >>> verilog/tm3_timer.v
// Function
// - One control register plus 8-bit period and pulse-width compare registers.
// - Clock select picks prescaled or raw fc, fs, fs/8 or the count pin.
// - Start bit 0 halts and clears the counter; 1 counts from zero.
// - Mode 0 timer, 1 divider, 2 PWM, 3 cascade; 1xx reserved.
// - Cascade needs mode 011 here; partner mode gives combined function.
// - Cascade takes clock here, start and flip-flop from the partner.
// - Raw fc in low-speed states only serves the warm-up function.
// - Partner upper byte counts this timer's overflow in cascade.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "tm3_map.vh"

module tm3_timer #(
	parameter CNT_W = 8
) (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       psel,
	input  wire       penable,
	input  wire       pwrite,
	input  wire [7:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg        pready,
	output reg        pslverr,
	input  wire [2:0] partner_timer_mode_field,
	input  wire       partner_timer_run_bit,
	input  wire       partner_timer_output_flipflop,
	input  wire       fs_clk_pin,
	input  wire       ext_count_pin,
	output reg        timer3_output_flipflop,
	output reg        timer3_overflow_r,
	output reg        timer3_running_r
);

	// -----------------------------------------------------------------
	// Storage
	// -----------------------------------------------------------------
	reg  [7:0]       timer3_control;
	reg  [1:0]       config_r;
	reg              viol_r;
	reg  [CNT_W-1:0] count_r;
	reg  [10:0]      presc_r;
	reg  [2:0]       fs_div_r;
	reg  [2:0]       fs_sync_r;
	reg  [2:0]       pin_sync_r;
	reg              run_d_r;
	wire [7:0]       timer3_period_compare;
	wire [7:0]       timer3_pulse_width_compare;

	wire [2:0] timer3_clock_select = timer3_control[`TM3_CTRL_CK_HI:
		`TM3_CTRL_CK_LO];
	wire       timer3_run_bit = timer3_control[`TM3_CTRL_RUN_BIT];
	wire [2:0] timer3_mode_field = timer3_control[`TM3_CTRL_MODE_HI:
		`TM3_CTRL_MODE_LO];
	wire       prescaler_source_option = config_r[`TM3_CFG_PRESC_BIT];
	wire       low_speed = config_r[`TM3_CFG_LOWSPD_BIT];

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	// A divided tick: the prescaler bit below the ratio wraps to zero.
	function div_tick;
		input [10:0] p;
		input [3:0]  n;
		begin
			div_tick = (p & ((11'h001 << n) - 11'h001)) ==
				((11'h001 << n) - 11'h001);
		end
	endfunction

	function pwm_mode;
		input [2:0] own_mode;
		input [2:0] partner_mode;
		begin
			pwm_mode = (own_mode == `TM3_MODE_PWM8) ||
				((own_mode == `TM3_MODE_CASCADE) &&
				(partner_mode == `TM3_PMODE_PWM16));
		end
	endfunction

	// -----------------------------------------------------------------
	// Run control and cascade selection
	// -----------------------------------------------------------------
	wire cascade = (timer3_mode_field == `TM3_MODE_CASCADE);
	wire reserved = timer3_mode_field[2];
	// In cascade the partner owns start/stop and the flip-flop.
	wire eff_run = !reserved &&
		(cascade ? partner_timer_run_bit : timer3_run_bit);
	wire eff_ff = cascade ? partner_timer_output_flipflop :
		timer3_control[`TM3_CTRL_FF_BIT];
	wire start_evt = eff_run && !run_d_r;
	wire warmup = cascade &&
		(partner_timer_mode_field == `TM3_PMODE_WARMUP);

	// -----------------------------------------------------------------
	// Count source selection
	// -----------------------------------------------------------------
	wire fs_tick = fs_sync_r[1] && !fs_sync_r[2];
	wire pin_tick = pin_sync_r[1] && !pin_sync_r[2];
	wire fs8_tick = fs_tick && (fs_div_r == 3'h7);
	reg  src_tick;
	reg  src_ok;

	always @*
	begin
		src_tick = 1'b0;
		src_ok = 1'b1;
		case (timer3_clock_select)
		`TM3_CK_DIV11:
			src_tick = (prescaler_source_option || low_speed) ?
				fs8_tick : div_tick(presc_r, `TM3_SH_DIV11);
		`TM3_CK_DIV7:
			src_tick = div_tick(presc_r, `TM3_SH_DIV7);
		`TM3_CK_DIV5:
			src_tick = div_tick(presc_r, `TM3_SH_DIV5);
		`TM3_CK_DIV3:
			src_tick = div_tick(presc_r, `TM3_SH_DIV3);
		`TM3_CK_FS:
			src_tick = fs_tick;
		`TM3_CK_DIV1:
			src_tick = div_tick(presc_r, `TM3_SH_DIV1);
		`TM3_CK_FC:
			src_tick = 1'b1;
		default:
			src_tick = pin_tick;
		endcase
		// In the low-speed states fc is stopped, except that raw fc may
		// feed the warm-up counter.
		if (low_speed)
		begin
			case (timer3_clock_select)
			`TM3_CK_DIV11, `TM3_CK_FS, `TM3_CK_PIN:
				src_ok = 1'b1;
			`TM3_CK_FC:
				src_ok = warmup;
			default:
				src_ok = 1'b0;
			endcase
		end
		if (!src_ok)
			src_tick = 1'b0;
	end

	// -----------------------------------------------------------------
	// Prescaler and pin synchronisers
	// -----------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			presc_r <= 11'h000;
			fs_div_r <= 3'h0;
			fs_sync_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end
		else
		begin
			presc_r <= presc_r + 11'h001;
			fs_sync_r <= {fs_sync_r[1:0], fs_clk_pin};
			pin_sync_r <= {pin_sync_r[1:0], ext_count_pin};
			if (fs_tick)
				fs_div_r <= fs_div_r + 3'h1;
		end
	end

	// -----------------------------------------------------------------
	// Counter, overflow and output flip-flop
	// -----------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_r <= {CNT_W{1'b0}};
			run_d_r <= 1'b0;
			timer3_overflow_r <= 1'b0;
			timer3_running_r <= 1'b0;
			timer3_output_flipflop <= 1'b0;
		end
		else
		begin
			run_d_r <= eff_run;
			timer3_running_r <= eff_run;
			timer3_overflow_r <= 1'b0;
			if (!eff_run)
				count_r <= {CNT_W{1'b0}};
			else if (src_tick)
			begin
				// Reaching the period restarts the count; the pulse is
				// what the partner upper byte counts in cascade.
				if (count_r == timer3_period_compare[CNT_W-1:0])
				begin
					count_r <= {CNT_W{1'b0}};
					timer3_overflow_r <= 1'b1;
				end
				else
					count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
			end
			if (start_evt)
				timer3_output_flipflop <= eff_ff;
		end
	end

	// -----------------------------------------------------------------
	// APB slave
	// -----------------------------------------------------------------
	// Every transfer is answered in its first access cycle, so the read
	// word and the error flag are prepared during the setup cycle.
	wire setup = psel && !penable;
	wire wr_acc = psel && penable && pready && pwrite && !pslverr;
	wire hit_ctrl = (paddr == `TM3_ADDR_CTRL);
	wire hit_per = (paddr == `TM3_ADDR_PERIOD);
	wire hit_pw = (paddr == `TM3_ADDR_PWIDTH);
	wire hit_stat = (paddr == `TM3_ADDR_STATUS);
	wire hit_cfg = (paddr == `TM3_ADDR_CONFIG);
	wire mapped = hit_ctrl || hit_per || hit_pw || hit_stat || hit_cfg;

	// Writes that software must not make while running are dropped and
	// flagged, so a broken driver cannot corrupt a live period.
	wire per_bad = hit_per && eff_run;
	wire pw_bad = hit_pw && eff_run &&
		!pwm_mode(timer3_mode_field, partner_timer_mode_field);
	wire [7:0] keep_mask = 8'hF7;
	wire ctrl_bad = hit_ctrl && timer3_run_bit &&
		((pwdata[7:0] & keep_mask) != (timer3_control & keep_mask));
	wire cmp_wr = wr_acc && ((hit_per && !per_bad) || (hit_pw && !pw_bad));
	wire viol_evt = wr_acc && (per_bad || pw_bad || ctrl_bad);
	wire viol_clr = wr_acc && hit_stat && pwdata[`TM3_STAT_VIOL_BIT];

	tm3_cmp_mem #(
		.WIDTH   (8)
	) u_cmp (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (cmp_wr),
		.wr_idx  (hit_pw),
		.wr_data (pwdata[7:0]),
		.word0_r (timer3_period_compare),
		.word1_r (timer3_pulse_width_compare)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer3_control <= `TM3_RST_CTRL;
			config_r <= `TM3_RST_CFG;
			viol_r <= 1'b0;
		end
		else
		begin
			if (wr_acc && hit_ctrl)
			begin
				// While running only the start bit is honoured, so a stop
				// write keeps mode, clock and flip-flop; a start from
				// stopped loads every field.
				if (timer3_run_bit)
					timer3_control[`TM3_CTRL_RUN_BIT] <=
						pwdata[`TM3_CTRL_RUN_BIT];
				else
					timer3_control <= pwdata[7:0];
			end
			if (wr_acc && hit_cfg)
				config_r <= pwdata[1:0];
			// Set wins over clear.
			if (viol_evt)
				viol_r <= 1'b1;
			else if (viol_clr)
				viol_r <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite)
			begin
				if (hit_ctrl)
					prdata <= {24'h000000, timer3_control};
				else if (hit_per)
					prdata <= {24'h000000, timer3_period_compare};
				else if (hit_pw)
					prdata <= {24'h000000, timer3_pulse_width_compare};
				else if (hit_stat)
					prdata <= {16'h0000, count_r, 4'h0, viol_r,
						src_ok, timer3_output_flipflop, eff_run};
				else if (hit_cfg)
					prdata <= {30'h00000000, config_r};
				else
					prdata <= 32'h00000000;
			end
			else if (setup)
				prdata <= 32'h00000000;
		end
	end

endmodule

// >>> verilog/tm3_map.vh
`ifndef TM3_MAP_VH
`define TM3_MAP_VH

// ---------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------
`define TM3_ADDR_CTRL        8'h00
`define TM3_ADDR_PERIOD      8'h04
`define TM3_ADDR_PWIDTH      8'h08
`define TM3_ADDR_STATUS      8'h0C
`define TM3_ADDR_CONFIG      8'h10

// ---------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------
`define TM3_CTRL_FF_BIT      7
`define TM3_CTRL_CK_HI       6
`define TM3_CTRL_CK_LO       4
`define TM3_CTRL_RUN_BIT     3
`define TM3_CTRL_MODE_HI     2
`define TM3_CTRL_MODE_LO     0

// ---------------------------------------------------------------------
// Status and configuration fields
// ---------------------------------------------------------------------
`define TM3_STAT_RUN_BIT     0
`define TM3_STAT_FF_BIT      1
`define TM3_STAT_SRC_OK_BIT  2
`define TM3_STAT_VIOL_BIT    3
`define TM3_STAT_CNT_LO      8
`define TM3_CFG_PRESC_BIT    0
`define TM3_CFG_LOWSPD_BIT   1

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define TM3_RST_CTRL         8'h00
`define TM3_RST_CMP          8'h00
`define TM3_RST_CFG          2'h0

// ---------------------------------------------------------------------
// Mode and clock select codes
// ---------------------------------------------------------------------
`define TM3_MODE_TIMER       3'h0
`define TM3_MODE_DIVIDER     3'h1
`define TM3_MODE_PWM8        3'h2
`define TM3_MODE_CASCADE     3'h3
`define TM3_PMODE_PWM16      3'h6
`define TM3_PMODE_WARMUP     3'h5
`define TM3_CK_DIV11         3'h0
`define TM3_CK_DIV7          3'h1
`define TM3_CK_DIV5          3'h2
`define TM3_CK_DIV3          3'h3
`define TM3_CK_FS            3'h4
`define TM3_CK_DIV1          3'h5
`define TM3_CK_FC            3'h6
`define TM3_CK_PIN           3'h7

// ---------------------------------------------------------------------
// Prescaler tap widths (log2 of each fc division ratio)
// ---------------------------------------------------------------------
`define TM3_SH_DIV11         4'hB
`define TM3_SH_DIV7          4'h7
`define TM3_SH_DIV5          4'h5
`define TM3_SH_DIV3          4'h3
`define TM3_SH_DIV1          4'h1

`endif

// >>> verilog/tm3_cmp_mem.v
`timescale 1ns/1ps
`include "tm3_map.vh"
// Holds the period word (index 0) and the pulse-width word (index 1).
// Both words are visible at once; the period match logic reads word 0
// continuously and word 1 is only read back; each comes straight out of its storage register.
module tm3_cmp_mem #(
	parameter WIDTH = 8
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             wr_en,
	input  wire             wr_idx,
	input  wire [WIDTH-1:0] wr_data,
	output reg  [WIDTH-1:0] word0_r,
	output reg  [WIDTH-1:0] word1_r
);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word0_r <= `TM3_RST_CMP;
			word1_r <= `TM3_RST_CMP;
		end
		else if (wr_en)
		begin
			if (wr_idx)
				word1_r <= wr_data;
			else
				word0_r <= wr_data;
		end
	end

endmodule

// >>> bench/tm3_timer_chk.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Port checker for the timer control block.
// ---------------------------------------------------------------------
module tm3_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        timer3_output_flipflop,
	input wire logic        timer3_overflow_r,
	input wire logic        timer3_running_r
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access cycle");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 0)
		else $error("refused read returned data");
	chk_upper_bits_zero: assert property (pready |-> prdata[31:16] == 0)
		else $error("unused read bits not zero");
	chk_idle_no_overflow: assert property (!timer3_running_r [*4] |-> !timer3_overflow_r)
		else $error("overflow while stopped");
	chk_ff_holds_stopped: assert property (!timer3_running_r ##1 !timer3_running_r
		|-> ##1 (timer3_running_r || $stable(timer3_output_flipflop)))
		else $error("flip-flop moved while stopped");
	cover property (pslverr);
	cover property ($rose(timer3_running_r));
	cover property (timer3_overflow_r);
endmodule
bind tm3_timer tm3_chk tm3_chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timer3_output_flipflop(timer3_output_flipflop),
	.timer3_overflow_r(timer3_overflow_r),
	.timer3_running_r(timer3_running_r)
);

// >>> bench/tm3_timer_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
// ---------------------------------------------------------------------
// Register-level tests over APB.
// ---------------------------------------------------------------------
module tm3_timer_tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, rerr, ff, ovf, run;
	logic [2:0]  pmode = 3'h0;
	logic        prun = 0, pff = 0, fs = 0, ext = 0;
	int          n_mismatch = 0, checks_done = 0, n;
	always #50 pclk = ~pclk;
	tm3_timer tm3_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.partner_timer_mode_field(pmode), .partner_timer_run_bit(prun),
		.partner_timer_output_flipflop(pff), .fs_clk_pin(fs),
		.ext_count_pin(ext), .timer3_output_flipflop(ff),
		.timer3_overflow_r(ovf), .timer3_running_r(run));
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task hang;
	begin
		n_mismatch++;
		tally_and_finish;
	end
	endtask
	// Setup at one edge, access held until pready is sampled high.
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20)
			hang;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task wait_ovf(output int i);
	begin
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end while (ovf !== 1'b1 && i < 300);
		if (i >= 300)
			hang;
	end
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			xfer(0, 8'(k * 4 + (k == 3 ? 4 : 0)), 0);
			`CHK(rdat, 32'h0)
		end
		xfer(0, 8'h14, 0);
		`CHK({rerr, rdat}, 33'h100000000)
		$display("reset and map test done");
		xfer(1, 8'h04, 8'h04);
		xfer(1, 8'h08, 8'h02);
		xfer(1, 8'h00, 8'h75);
		xfer(0, 8'h00, 0);
		`CHK(rdat, 32'h75)
		xfer(0, 8'h08, 0);
		`CHK(rdat, 32'h02)
		xfer(1, 8'h00, 8'hE8);
		wait_ovf(n);
		wait_ovf(n);
		`CHK(n, 5)
		`CHK({run, ff}, 2'h3)
		$display("count test done");
		xfer(1, 8'h04, 8'h09);
		xfer(0, 8'h04, 0);
		`CHK(rdat, 32'h04)
		xfer(0, 8'h0C, 0);
		`CHK(rdat[3], 1'b1)
		xfer(1, 8'h00, 8'hE9);
		xfer(0, 8'h00, 0);
		`CHK(rdat, 32'hE8)
		xfer(1, 8'h0C, 8'h08);
		xfer(0, 8'h0C, 0);
		`CHK(rdat[3], 1'b0)
		xfer(1, 8'h00, 8'hE0);
		xfer(0, 8'h0C, 0);
		`CHK({run, rdat[15:8]}, 9'h000)
		xfer(0, 8'h00, 0);
		`CHK(rdat, 32'hE0)
		$display("refusal test done");
		xfer(1, 8'h00, 8'h6C);
		repeat (3) @(posedge pclk);
		`CHK(run, 1'b0)
		xfer(1, 8'h00, 8'h64);
		pmode <= 3'h4;
		pff <= 1'b1;
		xfer(1, 8'h00, 8'h63);
		xfer(1, 8'h00, 8'h6B);
		repeat (3) @(posedge pclk);
		`CHK(run, 1'b0)
		prun <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK({run, ff}, 2'h3)
		prun <= 1'b0;
		xfer(1, 8'h00, 8'h63);
		xfer(1, 8'h10, 8'h02);
		xfer(0, 8'h0C, 0);
		`CHK(rdat[2], 1'b0)
		pmode <= 3'h5;
		xfer(0, 8'h0C, 0);
		`CHK(rdat[2], 1'b1)
		xfer(1, 8'h10, 8'h00);
		$display("cascade test done");
		xfer(1, 8'h04, 8'h09);
		xfer(1, 8'h00, 8'h78);
		repeat (3)
		begin
			ext <= 1'b1;
			repeat (3) @(posedge pclk);
			ext <= 1'b0;
			repeat (3) @(posedge pclk);
		end
		xfer(0, 8'h0C, 0);
		`CHK(rdat[15:8], 8'h03)
		$display("pin count test done");
		xfer(1, 8'h08, 8'h05);
		xfer(0, 8'h08, 0);
		`CHK(rdat, 32'h02)
		xfer(1, 8'h00, 8'h70);
		xfer(1, 8'h00, 8'h7A);
		xfer(1, 8'h08, 8'h05);
		xfer(0, 8'h08, 0);
		`CHK(rdat, 32'h05)
		xfer(1, 8'h00, 8'h72);
		pmode <= 3'h6;
		prun <= 1'b1;
		xfer(1, 8'h00, 8'h73);
		xfer(1, 8'h08, 8'h06);
		xfer(0, 8'h08, 0);
		`CHK(rdat, 32'h06)
		prun <= 1'b0;
		$display("compare write test done");
		xfer(1, 8'h04, 8'h04);
		xfer(1, 8'h00, 8'h38);
		wait_ovf(n);
		wait_ovf(n);
		`CHK(n, 40)
		$display("prescaler test done");
		tally_and_finish;
	end
endmodule
